// ===== bench/tb_top.sv
// testbench: random and corner-case checks of the timer, ready flag and wake pin block
`timescale 1ns/1ps
module tb_top
  import gtw_pkg::*;
;
  localparam int SETTLE = 16;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic wakeEvent = 1'b0;
  logic wakePinOut;
  logic wakePinOeN;
  logic irqOut;
  int err_total = 0;
  int num_checks = 0;
  int seedv;
  logic [31:0] rdv;
  logic [15:0] pre;
  logic [15:0] prevCnt;

  gtw_timer_ready_wake #(.SETTLE_CYC(SETTLE)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .wakeEvent(wakeEvent),
    .wakePinOut(wakePinOut), .wakePinOeN(wakePinOeN), .irqOut(irqOut)
  );

  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  // 200 mhz system clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // counter step with reload after zero
  function automatic logic [15:0] nextCnt(input logic [15:0] prev, input logic [15:0] p);
    return (prev == 16'h0000) ? p : prev - 16'h0001;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle write strobe
  task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // one-cycle read strobe, data sampled in the following cycle
  task automatic regRead(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic readChk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    regRead(a, d);
    chkWord(d, exp, what);
  endtask

  task automatic pulseWake();
    @(posedge clk_sys);
    wakeEvent <= 1'b1;
    @(posedge clk_sys);
    wakeEvent <= 1'b0;
  endtask

  // bounded poll of the ready flag; only the power control register is read meanwhile
  task automatic waitReady(output logic [31:0] d);
    d = 32'h00000000;
    for (int i = 0; i < 40 && d[GTW_BIT_READY] !== 1'b1; i++) begin
      regRead(GTW_OFS_PWR_CTRL, d);
    end
    if (d[GTW_BIT_READY] !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t ready never set", $time);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seedv = $urandom(32'h5d416649);
    idle(20);
    rstn <= 1'b1;
    // before ready only power control and hardware config are read, nothing written
    readChk(GTW_OFS_PWR_CTRL, 32'h00000000, "pwr before ready");
    regRead(GTW_OFS_HARDWARE_CONFIG_REG, rdv);
    chkWord(rdv & 32'h08000000, 32'h00000000, "hw ready early");
    chkBit(wakePinOeN, 1'b1, "pin idle");
    chkBit(irqOut, 1'b0, "irq idle");
    $display("test reset_state done");

    waitReady(rdv);
    chkWord(rdv, 32'h00000001, "ready, enable clear");
    readChk(GTW_OFS_TIMER_CFG, 32'h0000ffff, "cfg reset");
    readChk(GTW_OFS_TIMER_CNT, 32'h0000ffff, "cnt reset");
    regRead(GTW_OFS_HARDWARE_CONFIG_REG, rdv);
    chkWord(rdv & 32'h08000000, 32'h08000000, "hw ready");
    readChk(GTW_OFS_IRQ_STS, 32'h00000001, "ready status");
    regWrite(GTW_OFS_IRQ_MASK, 32'h00000001);
    idle(3);
    chkBit(irqOut, 1'b1, "ready irq");
    regWrite(GTW_OFS_IRQ_STS, 32'h00000001);
    idle(3);
    chkBit(irqOut, 1'b0, "ready irq cleared");
    regWrite(GTW_OFS_IRQ_MASK, 32'h00000000);
    readChk(12'h100, 32'h00000000, "unmapped read");
    $display("test ready_irq done");

    // wake event with pin disabled, then enabled
    pulseWake();
    idle(3);
    chkBit(wakePinOeN, 1'b1, "pin off while disabled");
    readChk(GTW_OFS_IRQ_STS, 32'h00000004, "wake status");
    regWrite(GTW_OFS_IRQ_STS, 32'h00000004);
    regWrite(GTW_OFS_PWR_CTRL, 32'h00000002);
    readChk(GTW_OFS_PWR_CTRL, 32'h00000003, "wake enable rw");
    chkBit(wakePinOeN, 1'b1, "pin off, no event");
    pulseWake();
    idle(3);
    chkBit(wakePinOeN, 1'b0, "pin driven");
    chkBit(wakePinOut, 1'b0, "pin low");
    regWrite(GTW_OFS_IRQ_MASK, 32'h00000004);
    idle(3);
    chkBit(irqOut, 1'b1, "wake irq");
    regWrite(GTW_OFS_PWR_CTRL, 32'h00000000);
    idle(3);
    chkBit(wakePinOeN, 1'b1, "pin released");
    regWrite(GTW_OFS_IRQ_STS, 32'h00000004);
    regWrite(GTW_OFS_IRQ_MASK, 32'h00000000);
    $display("test wake_pin done");

    // timer: preload 0, 1 and random, reserved bits set
    for (int t = 0; t < 3; t++) begin
      pre = (t < 2) ? 16'(t) : 16'($urandom_range(30, 2));
      regWrite(GTW_OFS_TIMER_CFG, {2'b11, 1'b1, 13'h1fff, pre});
      readChk(GTW_OFS_TIMER_CFG, {16'h2000, pre}, "cfg reserved");
      @(posedge clk_sys);
      regAddr <= GTW_OFS_TIMER_CNT;
      regRd <= 1'b1;
      for (int i = 0; i < 40; i++) begin
        @(posedge clk_sys);
        if (i == 39) begin
          regRd <= 1'b0;
        end
        #1;
        if (i == 0) begin
          chkBit(regRdata[15:0] <= pre, 1'b1, "cnt in range");
        end else begin
          chkWord(regRdata, {16'h0000, nextCnt(prevCnt, pre)}, "cnt step");
        end
        prevCnt = regRdata[15:0];
      end
      regWrite(GTW_OFS_TIMER_CFG, {16'h0000, pre});
      readChk(GTW_OFS_TIMER_CFG, 32'h0000ffff, "preload forced");
      regRead(GTW_OFS_TIMER_CNT, rdv);
      regWrite(GTW_OFS_TIMER_CNT, ~rdv);
      idle(5);
      readChk(GTW_OFS_TIMER_CNT, rdv, "cnt halted, read-only");
      regWrite(GTW_OFS_IRQ_MASK, 32'h00000002);
      idle(2);
      chkBit(irqOut, 1'b1, "timer irq");
      readChk(GTW_OFS_IRQ_STS, 32'h00000002, "timer status");
      regWrite(GTW_OFS_IRQ_STS, 32'h00000002);
      readChk(GTW_OFS_IRQ_STS, 32'h00000000, "timer status cleared");
      chkBit(irqOut, 1'b0, "timer irq cleared");
      regWrite(GTW_OFS_IRQ_MASK, 32'h00000000);
      $display("test timer preload %0d done", pre);
    end

    // reset in mid-run
    regWrite(GTW_OFS_TIMER_CFG, 32'h20000005);
    @(posedge clk_sys);
    rstn <= 1'b0;
    idle(3);
    chkBit(irqOut, 1'b0, "irq in reset");
    rstn <= 1'b1;
    readChk(GTW_OFS_PWR_CTRL, 32'h00000000, "ready after reset");
    waitReady(rdv);
    chkWord(rdv, 32'h00000001, "ready again");
    readChk(GTW_OFS_TIMER_CFG, 32'h0000ffff, "cfg after reset");
    readChk(GTW_OFS_TIMER_CNT, 32'h0000ffff, "cnt after reset");
    $display("test mid_reset done");
    give_verdict();
  end
endmodule

// ===== core/gtw_down_counter.sv
// down counter with reload and period pulse
`timescale 1ns/1ps
module gtw_down_counter
  import gtw_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic run,
  input wire logic [W-1:0] preload,
  output logic [W-1:0] count_r,
  output logic wrap_r
);
  logic runDly_r;

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      count_r <= W'(GTW_COUNT_RST);
      runDly_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      runDly_r <= run;
      wrap_r <= 1'b0;
      if (run && !runDly_r) begin
        count_r <= preload;
      end else if (run) begin
        if (count_r == '0) begin
          count_r <= preload;
          wrap_r <= 1'b1;
        end else begin
          count_r <= count_r - W'(1);
        end
      end
    end
  end

  AST_WRAP_RELOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (runDly_r && run && count_r == '0) |=> (wrap_r && count_r == $past(preload)))
    else $error("counter did not reload at zero");
  AST_HALT_HOLDS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!run ##1 !run) |-> $stable(count_r)) else $error("count moved while halted");
endmodule

// ===== core/gtw_pkg.sv
// package: register map, field positions, reset values and types for the timer block
package gtw_pkg;
  // register byte offsets
  localparam logic [11:0] GTW_OFS_TIMER_CFG = 12'h08c;
  localparam logic [11:0] GTW_OFS_TIMER_CNT = 12'h090;
  localparam logic [11:0] GTW_OFS_PWR_CTRL = 12'h084;
  localparam logic [11:0] GTW_OFS_HARDWARE_CONFIG_REG = 12'h074;
  localparam logic [11:0] GTW_OFS_IRQ_STS = 12'h058;
  localparam logic [11:0] GTW_OFS_IRQ_MASK = 12'h05c;
  // field positions
  localparam int GTW_BIT_TIMER_EN = 29;
  localparam int GTW_BIT_WAKE_EN = 1;
  localparam int GTW_BIT_READY = 0;
  localparam int GTW_BIT_HW_READY = 27;
  localparam int GTW_BIT_IRQ_READY = 0;
  localparam int GTW_BIT_IRQ_TIMER = 1;
  localparam int GTW_BIT_IRQ_WAKE = 2;
  localparam int GTW_IRQ_W = 3;
  // reset values
  localparam logic [15:0] GTW_PRELOAD_RST = 16'hffff;
  localparam logic [15:0] GTW_COUNT_RST = 16'hffff;
  // settle time before ready, in ns, and its cycle count at 200 MHz
  localparam int GTW_SETTLE_NS = 1000;
  localparam int GTW_CLK_PERIOD_NS = 5;
  localparam int GTW_SETTLE_CYC = (GTW_SETTLE_NS + GTW_CLK_PERIOD_NS - 1) / GTW_CLK_PERIOD_NS;

  // register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gtw_bus_req_t;

  // ready sequencer states, gray ordered
  typedef enum logic [1:0] {
    GTW_ST_RESET = 2'b00,
    GTW_ST_SETTLE = 2'b01,
    GTW_ST_READY = 2'b11
  } gtw_ready_st_t;
endpackage

// ===== core/gtw_ready_seq.sv
// ready sequencer: holds ready low until internal logic has settled
`timescale 1ns/1ps
module gtw_ready_seq
  import gtw_pkg::*;
#(
  parameter int SETTLE_CYC = GTW_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic ready_r
);
  gtw_ready_st_t state_r;
  logic [15:0] waitCnt_r;

  // ---------------------------------------------------------------
  // settle sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_r <= GTW_ST_RESET;
      waitCnt_r <= 16'h0000;
      ready_r <= 1'b0;
    end else begin
      case (state_r)
        GTW_ST_RESET: begin
          state_r <= GTW_ST_SETTLE;
          waitCnt_r <= 16'h0000;
        end
        GTW_ST_SETTLE: begin
          waitCnt_r <= waitCnt_r + 16'h0001;
          if (waitCnt_r == 16'(SETTLE_CYC - 1)) begin
            state_r <= GTW_ST_READY;
            ready_r <= 1'b1;
          end
        end
        GTW_ST_READY: begin
          ready_r <= 1'b1;
        end
        default: begin
          state_r <= GTW_ST_RESET;
        end
      endcase
    end
  end

  AST_READY_LOW_AFTER_RESET: assert property (@(posedge clk_sys)
    !rstn |=> !ready_r) else $error("ready set right after reset");
endmodule

// ===== core/gtw_timer_ready_wake.sv
// top: general timer, ready flag, wake pin enable and interrupt registers
`timescale 1ns/1ps
module gtw_timer_ready_wake
  import gtw_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int SETTLE_CYC = GTW_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic wakeEvent,
  output logic wakePinOut,
  output logic wakePinOeN,
  output logic irqOut
);
  gtw_bus_req_t req;
  logic ready;
  logic timerEn_r;
  logic [CNT_W-1:0] preload_r;
  logic [CNT_W-1:0] count;
  logic wrap;
  logic wakeEn_r;
  logic wakeLatch_r;
  logic readyDly_r;
  logic [GTW_IRQ_W-1:0] irqSts_r;
  logic [GTW_IRQ_W-1:0] irqMask_r;
  logic [GTW_IRQ_W-1:0] irqEvt;
  logic [GTW_IRQ_W-1:0] irqClr;
  logic [31:0] rdMux;
  logic [31:0] regRdata_r;
  logic irq_r;
  logic pinOut_r;
  logic pinOeN_r;
  logic wrOk;

  // ---------------------------------------------------------------
  // bus request bundle
  // ---------------------------------------------------------------
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  // writes before ready are dropped; the host must not issue them anyway
  assign wrOk = req.wr && ready;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  gtw_ready_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) uReady (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ready_r(ready)
  );

  gtw_down_counter #(
    .W(CNT_W)
  ) uCnt (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run(timerEn_r),
    .preload(preload_r),
    .count_r(count),
    .wrap_r(wrap)
  );

  // ---------------------------------------------------------------
  // timer configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      timerEn_r <= 1'b0;
      preload_r <= CNT_W'(GTW_PRELOAD_RST);
    end else if (wrOk && req.addr == GTW_OFS_TIMER_CFG) begin
      timerEn_r <= req.wdata[GTW_BIT_TIMER_EN];
      if (timerEn_r && !req.wdata[GTW_BIT_TIMER_EN]) begin
        preload_r <= CNT_W'(GTW_PRELOAD_RST);
      end else begin
        preload_r <= req.wdata[CNT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // power management control: wake pin enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wakeEn_r <= 1'b0;
    end else if (wrOk && req.addr == GTW_OFS_PWR_CTRL) begin
      wakeEn_r <= req.wdata[GTW_BIT_WAKE_EN];
    end
  end

  // ---------------------------------------------------------------
  // wake pin: latched event, cleared with the status bit, open-drain low
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wakeLatch_r <= 1'b0;
      pinOut_r <= 1'b0;
      pinOeN_r <= 1'b1;
    end else begin
      if (wakeEvent) begin
        wakeLatch_r <= 1'b1;
      end else if (irqClr[GTW_BIT_IRQ_WAKE]) begin
        wakeLatch_r <= 1'b0;
      end
      pinOut_r <= 1'b0; // active low
      pinOeN_r <= !(wakeEn_r && (wakeLatch_r || wakeEvent));
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      readyDly_r <= 1'b0;
    end else begin
      readyDly_r <= ready;
    end
  end

  assign irqEvt[GTW_BIT_IRQ_READY] = ready && !readyDly_r;
  assign irqEvt[GTW_BIT_IRQ_TIMER] = wrap;
  assign irqEvt[GTW_BIT_IRQ_WAKE] = wakeEvent;
  assign irqClr = (wrOk && req.addr == GTW_OFS_IRQ_STS) ? req.wdata[GTW_IRQ_W-1:0] : '0;

  // per-bit sticky status, set wins over clear
  for (genvar i = 0; i < GTW_IRQ_W; i++) begin : gSts
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        irqSts_r[i] <= 1'b0;
      end else if (irqEvt[i]) begin
        irqSts_r[i] <= 1'b1;
      end else if (irqClr[i]) begin
        irqSts_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqMask_r <= '0;
    end else if (wrOk && req.addr == GTW_OFS_IRQ_MASK) begin
      irqMask_r <= req.wdata[GTW_IRQ_W-1:0];
    end
  end

  // interrupt output registered
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irqSts_r & irqMask_r);
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    case (req.addr)
      GTW_OFS_TIMER_CFG: begin
        rdMux[GTW_BIT_TIMER_EN] = timerEn_r;
        rdMux[CNT_W-1:0] = preload_r;
      end
      GTW_OFS_TIMER_CNT: begin
        rdMux[CNT_W-1:0] = count;
      end
      GTW_OFS_PWR_CTRL: begin
        rdMux[GTW_BIT_WAKE_EN] = wakeEn_r;
        rdMux[GTW_BIT_READY] = ready;
      end
      GTW_OFS_HARDWARE_CONFIG_REG: begin
        rdMux[GTW_BIT_HW_READY] = ready;
      end
      GTW_OFS_IRQ_STS: begin
        rdMux[GTW_IRQ_W-1:0] = irqSts_r;
      end
      GTW_OFS_IRQ_MASK: begin
        rdMux[GTW_IRQ_W-1:0] = irqMask_r;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      regRdata_r <= 32'h0000_0000;
    end else if (req.rd) begin
      regRdata_r <= rdMux;
    end else begin
      regRdata_r <= 32'h0000_0000;
    end
  end

  assign regRdata = regRdata_r;
  assign irqOut = irq_r;
  assign wakePinOut = pinOut_r;
  assign wakePinOeN = pinOeN_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence sCfgWrOff;
    wrOk && req.addr == GTW_OFS_TIMER_CFG && timerEn_r && !req.wdata[GTW_BIT_TIMER_EN];
  endsequence

  AST_PIN_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
    !wakeEn_r |=> wakePinOeN) else $error("wake pin driven while disabled");
  AST_WAKE_STS_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    wakeEvent |=> irqSts_r[GTW_BIT_IRQ_WAKE]) else $error("wake flag not set");
  AST_WAKE_EN_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrOk && req.addr == GTW_OFS_PWR_CTRL) |=> wakeEn_r == $past(req.wdata[1]))
    else $error("wake enable not written");
  AST_READY_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (irqSts_r[GTW_BIT_IRQ_READY] && irqMask_r[GTW_BIT_IRQ_READY]) |=> irqOut)
    else $error("ready irq missing");
  AST_NO_WR_UNREADY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ready && req.wr) |=> $stable(timerEn_r) && $stable(wakeEn_r))
    else $error("write taken before ready");
  AST_HW_MIRROR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rd && req.addr == GTW_OFS_HARDWARE_CONFIG_REG) |=> regRdata[GTW_BIT_HW_READY] == $past(ready))
    else $error("ready mirror wrong");
  AST_PRELOAD_FORCE: assert property (@(posedge clk_sys) disable iff (!rstn)
    sCfgWrOff |=> preload_r == GTW_PRELOAD_RST && !timerEn_r)
    else $error("preload not forced");
  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rd && req.addr == GTW_OFS_TIMER_CFG) |=> regRdata[31:30] == 2'h0
    && regRdata[28:16] == 13'h0000) else $error("reserved bits nonzero");
  AST_CNT_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rd && req.addr == GTW_OFS_TIMER_CNT) |=> regRdata[15:0] == $past(count))
    else $error("count read wrong");
  AST_TIMER_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrap |=> irqSts_r[GTW_BIT_IRQ_TIMER]) else $error("timer flag not set");
endmodule
